/* File: src/bpe_top.sv */
// Booster phase enable, multichip configuration and peak share logic behind an AHB-Lite slave.
// Function
// - Sync edge invert bit resets to zero.
// - Master role lets amp drive compensation.
// - Slave role only senses compensation node.
// - Overvoltage detected locally per chip.
// - Pin falling edge enters failsafe mode while pin function select is zero.
// - Bit edges enable and disable phases.
// - Pin mode needs bit and pin high.
// - Bit zero holds gate drive off.
// - Amplifier stays on with phases off.
// - Per phase code selects sense divider.
// - Code is signed; ratio from formula.
// - Slope divided by the divider ratio.
// - Gate follows chosen booster clock edge.
`timescale 1ns/100ps
module bpe_top #(
  parameter int PHASES = 2
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins.
  input wire logic boost_clk_pin,
  input wire logic fso_enable_pin,
  input wire logic [PHASES-1:0] phase_enable_pin,
  input wire logic [PHASES-1:0] boost_feedback_ov,
  // Analog side.
  output bpe_pkg::bpe_cfg_s cfg_out,
  output logic comp_drive_en,
  output logic [PHASES-1:0] gate_drive,
  output logic [PHASES*14-1:0] div_ratio_x100,
  output logic [PHASES*14-1:0] slope_x100,
  output logic failsafe_operating_mode
);

  initial
  begin
    if (PHASES < 1 || PHASES > 4)
    begin
      $error("PHASES must be 1 to 4.");
    end
  end

  // Divider ratio in 1/100 units; codes 16 to 31 stand for -1 down to -16.
  function automatic logic [13:0] div_x100(input logic [4:0] code);
    int s;
    s = code[4] ? 15 - int'(code) : int'(code);
    return 14'(bpe_pkg::DIV_NUM_X100 / (bpe_pkg::DIV_BASE + bpe_pkg::DIV_STEP * (bpe_pkg::DIV_TOP - s)));
  endfunction : div_x100

  // Internal slope in mV/us from its select code.
  function automatic logic [8:0] slope_mv(input logic [2:0] sel);
    case (sel)
      3'h1: return 9'd17;
      3'h2: return 9'd35;
      3'h3: return 9'd50;
      3'h4: return 9'd85;
      3'h5: return 9'd120;
      3'h6: return 9'd190;
      3'h7: return 9'd290;
      default: return 9'd0;
    endcase
  endfunction : slope_mv

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus state.
  logic [PHASES-1:0] en_bit_ff, nxt_en_bit;
  bpe_pkg::bpe_cfg_s cfg_ff, nxt_cfg;
  logic [PHASES-1:0][4:0] peak_ff, nxt_peak;
  logic [2:0] slope_ff, nxt_slope;
  logic fso_ff, nxt_fso;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [PHASES-1:0] ov_seen;

  // Synchronisers and debounce.
  logic [2:0] clk_sync_ff;
  logic [2:0] fso_sync_ff;
  logic [PHASES-1:0] pen_s1_ff, pen_s2_ff, pen_deb_ff, nxt_pen_deb;
  logic [PHASES-1:0][2:0] pen_cnt_ff, nxt_pen_cnt;
  logic [PHASES-1:0][2:0] ov_sync_ff;
  logic [PHASES-1:0] phase_on;
  logic clk_edge;

  wire logic acc = hsel && hready && htrans == bpe_pkg::HTRANS_NONSEQ;
  wire logic fso_fall = fso_sync_ff[2] && !fso_sync_ff[1];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and register file.
  always_comb
  begin
    nxt_en_bit = en_bit_ff;
    nxt_cfg = cfg_ff;
    nxt_peak = peak_ff;
    nxt_slope = slope_ff;
    nxt_fso = fso_ff;
    nxt_wr_pend = acc && hwrite;
    nxt_wr_addr = haddr[7:0];
    nxt_hrdata = hrdata_ff;
    if (wr_pend_ff)
    begin
      unique case (wr_addr_ff)
        bpe_pkg::ADDR_CTRL:
        begin
          nxt_en_bit = hwdata[bpe_pkg::CTRL_EN_LSB +: PHASES];
          nxt_cfg.pin_function_select = hwdata[bpe_pkg::CTRL_PINSEL_BIT];
          nxt_cfg.sync_edge_invert = hwdata[bpe_pkg::CTRL_INV_BIT];
          nxt_cfg.phase_role_select = hwdata[bpe_pkg::CTRL_ROLE_LSB +: 2];
          nxt_cfg.error_amp_gain = hwdata[bpe_pkg::CTRL_GAIN_LSB +: 2];
          if (hwdata[bpe_pkg::CTRL_FSO_CLR_BIT])
          begin
            nxt_fso = 1'b0;
          end
        end
        bpe_pkg::ADDR_PEAK:
        begin
          for (int i = 0; i < PHASES; i++)
          begin
            nxt_peak[i] = hwdata[i*bpe_pkg::PEAK_STRIDE +: bpe_pkg::PEAK_W];
          end
        end
        bpe_pkg::ADDR_SLOPE: nxt_slope = hwdata[2:0];
        default: nxt_slope = slope_ff;
      endcase
    end
    // Failsafe entry wins over a clear in the same cycle.
    if (!cfg_ff.pin_function_select && fso_fall)
    begin
      nxt_fso = 1'b1;
    end
    if (acc && !hwrite)
    begin
      nxt_hrdata = 32'h0;
      unique case (haddr[7:0])
        bpe_pkg::ADDR_CTRL:
        begin
          nxt_hrdata[bpe_pkg::CTRL_EN_LSB +: PHASES] = en_bit_ff;
          nxt_hrdata[bpe_pkg::CTRL_PINSEL_BIT] = cfg_ff.pin_function_select;
          nxt_hrdata[bpe_pkg::CTRL_INV_BIT] = cfg_ff.sync_edge_invert;
          nxt_hrdata[bpe_pkg::CTRL_ROLE_LSB +: 2] = cfg_ff.phase_role_select;
          nxt_hrdata[bpe_pkg::CTRL_GAIN_LSB +: 2] = cfg_ff.error_amp_gain;
        end
        bpe_pkg::ADDR_PEAK:
        begin
          for (int i = 0; i < PHASES; i++)
          begin
            nxt_hrdata[i*bpe_pkg::PEAK_STRIDE +: bpe_pkg::PEAK_W] = peak_ff[i];
          end
        end
        bpe_pkg::ADDR_SLOPE: nxt_hrdata[2:0] = slope_ff;
        bpe_pkg::ADDR_STATUS:
        begin
          nxt_hrdata[PHASES-1:0] = phase_on;
          nxt_hrdata[8 +: PHASES] = ov_seen;
          nxt_hrdata[16] = fso_ff;
        end
        default: nxt_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_bit_ff <= '0;
      cfg_ff.sync_edge_invert <= bpe_pkg::sync_edge_invert_rst;
      cfg_ff.phase_role_select <= bpe_pkg::ROLE_RST;
      cfg_ff.error_amp_gain <= bpe_pkg::GAIN_RST;
      cfg_ff.pin_function_select <= 1'b0;
      peak_ff <= {PHASES{bpe_pkg::PEAK_RST}};
      slope_ff <= bpe_pkg::SLOPE_RST;
      fso_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
    end
    else
    begin
      en_bit_ff <= nxt_en_bit;
      cfg_ff <= nxt_cfg;
      peak_ff <= nxt_peak;
      slope_ff <= nxt_slope;
      fso_ff <= nxt_fso;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and enable pin debounce.
  always_comb
  begin
    nxt_pen_deb = pen_deb_ff;
    nxt_pen_cnt = pen_cnt_ff;
    for (int i = 0; i < PHASES; i++)
    begin
      if (pen_s2_ff[i] == pen_deb_ff[i])
      begin
        nxt_pen_cnt[i] = 3'h0;
      end
      else if (pen_cnt_ff[i] == 3'(bpe_pkg::DEB_CYCLES - 1))
      begin
        nxt_pen_cnt[i] = 3'h0;
        nxt_pen_deb[i] = pen_s2_ff[i];
      end
      else
      begin
        nxt_pen_cnt[i] = pen_cnt_ff[i] + 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_sync_ff <= 3'h0;
      fso_sync_ff <= 3'h7;
      pen_s1_ff <= '0;
      pen_s2_ff <= '0;
      pen_deb_ff <= '0;
      pen_cnt_ff <= '0;
      ov_sync_ff <= '0;
    end
    else
    begin
      clk_sync_ff <= {clk_sync_ff[1:0], boost_clk_pin};
      fso_sync_ff <= {fso_sync_ff[1:0], fso_enable_pin};
      pen_s1_ff <= phase_enable_pin;
      pen_s2_ff <= pen_s1_ff;
      pen_deb_ff <= nxt_pen_deb;
      pen_cnt_ff <= nxt_pen_cnt;
      for (int i = 0; i < PHASES; i++)
      begin
        ov_sync_ff[i] <= {ov_sync_ff[i][1:0], boost_feedback_ov[i]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase gating, gate drive and analog settings.
  always_comb
  begin
    // Edge chosen by the invert bit: rising when zero, falling when one.
    clk_edge = cfg_ff.sync_edge_invert ? (clk_sync_ff[2] && !clk_sync_ff[1])
                                       : (!clk_sync_ff[2] && clk_sync_ff[1]);
    for (int i = 0; i < PHASES; i++)
    begin
      ov_seen[i] = ov_sync_ff[i][2];
      if (cfg_ff.pin_function_select)
      begin
        phase_on[i] = en_bit_ff[i] && pen_deb_ff[i];
      end
      else
      begin
        phase_on[i] = en_bit_ff[i];
      end
    end
  end

  logic [PHASES-1:0] gate_ff, nxt_gate;
  always_comb
  begin
    nxt_gate = gate_ff;
    for (int i = 0; i < PHASES; i++)
    begin
      if (!en_bit_ff[i] || !phase_on[i] || ov_seen[i])
      begin
        nxt_gate[i] = 1'b0;
      end
      else if (clk_edge)
      begin
        nxt_gate[i] = 1'b1;
      end
    end
  end

  logic [PHASES*14-1:0] div_ff, nxt_div, slp_ff, nxt_slp;
  always_comb
  begin
    for (int i = 0; i < PHASES; i++)
    begin
      nxt_div[i*14 +: 14] = div_x100(peak_ff[i]);
      nxt_slp[i*14 +: 14] = 14'((32'(slope_mv(slope_ff)) * 32'd10000) / 32'(div_x100(peak_ff[i])));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_ff <= '0;
      div_ff <= '0;
      slp_ff <= '0;
    end
    else
    begin
      gate_ff <= nxt_gate;
      div_ff <= nxt_div;
      slp_ff <= nxt_slp;
    end
  end

  assign gate_drive = gate_ff;
  assign div_ratio_x100 = div_ff;
  assign slope_x100 = slp_ff;
  assign cfg_out = cfg_ff;
  assign failsafe_operating_mode = fso_ff;
  // Amplifier drives the shared node only as master; never gated by phase state.
  assign comp_drive_en = cfg_ff.phase_role_select == bpe_pkg::ROLE_MASTER;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_gate_off_bit:
    assert property (@(posedge hclk) disable iff (!hresetn) !en_bit_ff[0] |=> !gate_drive[0])
    else $error("Gate on with enable bit low.");
  a_pin_mode_gate:
    assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_ff.pin_function_select && !pen_deb_ff[0] |=> !gate_drive[0])
    else $error("Gate on with enable pin low.");
  a_fso_entry:
    assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_ff.pin_function_select && fso_fall |=> failsafe_operating_mode)
    else $error("Failsafe not entered.");
  a_comp_slave:
    assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_ff.phase_role_select == bpe_pkg::ROLE_SLAVE |-> !comp_drive_en)
    else $error("Slave drives compensation.");
  a_comp_master:
    assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_ff.phase_role_select == bpe_pkg::ROLE_MASTER && phase_on == '0 |-> comp_drive_en)
    else $error("Master not driving compensation.");
  a_gate_edge:
    assert property (@(posedge hclk) disable iff (!hresetn) $rose(gate_drive[0]) |-> $past(clk_edge))
    else $error("Gate rose without clock edge.");
  a_div_min:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $past(peak_ff[0]) == 5'h1f |-> div_ratio_x100[13:0] == 14'd400)
    else $error("Divider ratio wrong for lowest code.");
  a_ov_local:
    assert property (@(posedge hclk) disable iff (!hresetn) ov_seen[0] |=> !gate_drive[0])
    else $error("Gate on during overvoltage.");
  a_deb_hold:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(pen_deb_ff[0]) |-> $past(pen_s2_ff[0], 1) == pen_deb_ff[0])
    else $error("Debounce changed without input.");
endmodule : bpe_top

/* File: src/bpe_pkg.sv */
// Package with register map, field layouts and constants of the booster phase enable block.
package bpe_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PEAK = 8'h04;
  localparam logic [7:0] ADDR_SLOPE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Control register field positions.
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_PINSEL_BIT = 4;
  localparam int CTRL_INV_BIT = 5;
  localparam int CTRL_ROLE_LSB = 6;
  localparam int CTRL_GAIN_LSB = 8;
  localparam int CTRL_FSO_CLR_BIT = 12;

  // Peak share code field positions.
  localparam int PEAK_W = 5;
  localparam int PEAK_STRIDE = 8;

  // Reset values.
  localparam logic sync_edge_invert_rst = 1'b0;
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic [4:0] PEAK_RST = 5'h0f;
  localparam logic [2:0] SLOPE_RST = 3'h0;

  // Phase role encodings.
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE = 2'h2;

  // Divider math: ratio = 1/(1/20+(15-s)/155) = 3100/(155+20*(15-s)), in 1/100 units.
  localparam int DIV_NUM_X100 = 310000;
  localparam int DIV_BASE = 155;
  localparam int DIV_STEP = 20;
  localparam int DIV_TOP = 15;

  // Debounce length in clock cycles.
  localparam int DEB_CYCLES = 4;

  // AHB transfer type.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Settings that steer the analog side.
  typedef struct packed {
    logic sync_edge_invert;
    logic [1:0] phase_role_select;
    logic [1:0] error_amp_gain;
    logic pin_function_select;
  } bpe_cfg_s;

endpackage : bpe_pkg

/* File: tb/bpe_clk_src.sv */
// Host side model that supplies the shared booster clock.
`timescale 1ns/100ps
module bpe_clk_src #(
  parameter int HALF = 10
) (
  // Clock and run control.
  input wire logic hclk,
  input wire logic run,
  // Booster clock pin.
  output logic boost_clk_pin
);
  int cnt;
  initial boost_clk_pin = 1'b0;
  initial cnt = 0;
  // The clock stands low while the host does not run it.
  always @(posedge hclk)
  begin
    if (!run)
    begin
      boost_clk_pin <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      boost_clk_pin <= ~boost_clk_pin;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : bpe_clk_src

/* File: tb/testbench.sv */
// Self-checking testbench for the booster phase enable block.
`timescale 1ns/100ps
module testbench;
  localparam int HALF = 10;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, run, fso_pin, cde, fs;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pin, ov, gate;
  logic [2:0] hsize;
  logic [27:0] ratio, slope;
  bpe_pkg::bpe_cfg_s cfg;
  logic bclk;
  int error_cnt = 0;
  int check_count = 0;
  int ex[8] = '{0, 425, 875, 1250, 2125, 3000, 4750, 7250};
  int pc[5] = '{31, 15, 0, 14, 27};
  int pr[5] = '{400, 2000, 681, 1771, 446};
  assign hready = hreadyout;
  bpe_clk_src #(.HALF(HALF)) src_u (.hclk(hclk), .run(run), .boost_clk_pin(bclk));
  bpe_top #(.PHASES(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .boost_clk_pin(bclk), .fso_enable_pin(fso_pin), .phase_enable_pin(pin),
    .boost_feedback_ov(ov), .cfg_out(cfg), .comp_drive_en(cde), .gate_drive(gate), .div_ratio_x100(ratio),
    .slope_x100(slope), .failsafe_operating_mode(fs));
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Tasks.
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= bpe_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("hresp", hresp, 1'b0);
    @(negedge hclk);
  endtask : ahb
  task automatic wr_ctrl(input logic [1:0] en, input logic ps, input logic inv, input logic [1:0] role,
    input logic [1:0] gain);
    ahb(1'b1, 32'h0, {22'h0, gain, role, inv, ps, 2'h0, en});
  endtask : wr_ctrl
  task automatic wait_gate(input int i, input logic e, input int n);
    for (int k = 0; k < n && gate[i] !== e; k++) @(negedge hclk);
    check("gate", gate[i], e);
  endtask : wait_gate
  ////////////////////////////////////////////////////////////////////////////////
  // Tests.
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    {hresetn, hsel, hwrite, run, pin, ov, htrans, hsize} = '0;
    fso_pin = 1'b1;
    haddr = '0;
    hwdata = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    @(negedge hclk);
    check("cfg", cfg, '0);
    check("ratio", ratio[13:0], 2000);
    check("failsafe idle", fs, 1'b0);
    ahb(1'b0, 32'h4, 0);
    check("peak", rd, 32'h0f0f);
    ahb(1'b1, 32'h20, 32'hffff);
    ahb(1'b0, 32'h20, 0);
    check("unmapped", rd, 0);
    wr_ctrl(2'h0, 1'b0, 1'b0, bpe_pkg::ROLE_MASTER, 2'h3);
    check("comp", cde, 1'b1);
    check("gain", cfg.error_amp_gain, 2'h3);
    wr_ctrl(2'h0, 1'b0, 1'b1, bpe_pkg::ROLE_SLAVE, 2'h0);
    check("comp", cde, 1'b0);
    check("inv", cfg.sync_edge_invert, 1'b1);
    check("gain", cfg.error_amp_gain, 2'h0);
    for (int k = 0; k < 5; k++)
    begin
      ahb(1'b1, 32'h4, 32'h0f00 | pc[k]);
      @(negedge hclk);
      check("ratio0", ratio[13:0], pr[k]);
      check("ratio1", ratio[27:14], 2000);
    end
    ahb(1'b1, 32'h4, 32'h1f1f);
    for (int k = 0; k < 8; k++)
    begin
      ahb(1'b1, 32'h8, k);
      @(negedge hclk);
      check("slope", slope[13:0], ex[k]);
    end
    wr_ctrl(2'h1, 1'b0, 1'b0, 2'h0, 2'h0);
    repeat (6) @(negedge hclk);
    check("gate idle", gate[0], 1'b0);
    run <= 1'b1;
    wait_gate(0, 1'b1, HALF + 8);
    run <= 1'b0;
    wr_ctrl(2'h0, 1'b0, 1'b1, 2'h0, 2'h0);
    wait_gate(0, 1'b0, 4);
    wr_ctrl(2'h1, 1'b0, 1'b1, 2'h0, 2'h0);
    run <= 1'b1;
    repeat (HALF + 6) @(negedge hclk);
    check("gate rise", gate[0], 1'b0);
    wait_gate(0, 1'b1, HALF + 8);
    wr_ctrl(2'h3, 1'b0, 1'b0, 2'h0, 2'h0);
    wait_gate(1, 1'b1, 4 * HALF);
    ov <= 2'h1;
    wait_gate(0, 1'b0, 8);
    check("gate other", gate[1], 1'b1);
    ov <= 2'h0;
    wr_ctrl(2'h1, 1'b1, 1'b0, 2'h0, 2'h0);
    repeat (4 * HALF) @(negedge hclk);
    check("gate pin low", gate[0], 1'b0);
    pin <= 2'h1;
    wait_gate(0, 1'b1, 4 * HALF);
    ahb(1'b0, 32'hc, 0);
    check("status", rd[0], 1'b1);
    pin <= 2'h0;
    wait_gate(0, 1'b0, 12);
    wr_ctrl(2'h0, 1'b0, 1'b0, 2'h0, 2'h0);
    fso_pin <= 1'b1;
    repeat (8) @(negedge hclk);
    fso_pin <= 1'b0;
    repeat (8) @(negedge hclk);
    check("failsafe", fs, 1'b1);
    ahb(1'b1, 32'h0, 32'h1000);
    @(negedge hclk);
    check("failsafe clr", fs, 1'b0);
    print_verdict();
  end
endmodule : testbench
